//--- include/cstm_pkg.sv
// cstm_pkg: constants shared by the charge status and test-mode logic.
// assumes a 125 MHz reference clock; timer units are half minutes.
package cstm_pkg;

   // reference clock period in ns and rate
   localparam int unsigned CLK_PERIOD_NS = 8;
   // fine timebase tick: half a minute divided by 512, in ns
   localparam longint unsigned FINE_TICK_NS = 64'h00000000037E11D6;
   // fine tick as clock cycles, rounded up
   localparam int unsigned FINE_TICK_CYC = int'((FINE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // fine ticks per normal timer unit (test mode shortens safety/initial by this)
   localparam int unsigned SAFE_TEST_DIV = 512;
   // test-mode peak timer unit in fine ticks (512 / 64)
   localparam int unsigned PEAK_TEST_FINE = 8;
   // fine ticks per half period of the blink output
   localparam int unsigned BLINK_HALF_FINE = 2;

   // timer counter width, half-minute units
   localparam int unsigned TMR_W = 9;
   // timer-select codes seen on the two select pins
   localparam logic [1:0] TSEL_LOW = 2'h0;
   localparam logic [1:0] TSEL_HIGH = 2'h1;
   localparam logic [1:0] TSEL_FLOAT = 2'h2;
   // limits in half minutes: safety 40/80/160, peak 2/4/8, initial 1.5/3/3 min
   localparam logic [TMR_W-1:0] SAFE_HIGH = 9'h050;
   localparam logic [TMR_W-1:0] SAFE_LOW = 9'h0A0;
   localparam logic [TMR_W-1:0] SAFE_FLOAT = 9'h140;
   localparam logic [TMR_W-1:0] PEAK_HIGH = 9'h004;
   localparam logic [TMR_W-1:0] PEAK_LOW = 9'h008;
   localparam logic [TMR_W-1:0] PEAK_FLOAT = 9'h010;
   localparam logic [TMR_W-1:0] INIT_HIGH = 9'h003;
   localparam logic [TMR_W-1:0] INIT_LOW = 9'h006;
   localparam logic [TMR_W-1:0] INIT_FLOAT = 9'h006;
   // timer reset value
   localparam logic [TMR_W-1:0] TMR_ZERO = 9'h000;

   // number of synchronised input bits
   localparam int unsigned SYNC_N = 8;

   // charge state machine
   typedef enum logic [2:0] {
      CSTM_ST_RESET,
      CSTM_ST_CHECK,
      CSTM_ST_FAST,
      CSTM_ST_TRICKLE,
      CSTM_ST_ABNORMAL
   } cstm_state_t;

endpackage : cstm_pkg

//--- rtl/cstm_timebase.sv
// cstm_timebase: divides the reference clock into the fine tick, the slow
// timer ticks and the blink phase. assumes a synchronous, clean clock.
`timescale 1ns/100ps
module cstm_timebase
   import cstm_pkg::*;
#(
   parameter int unsigned FINE_CYC = FINE_TICK_CYC
)
(
   input wire logic ref_clk,
   input wire logic nrst,
   output logic fine_tick,
   output logic slow_tick,
   output logic peak_test_tick,
   output logic blink_phase
);

   // cycle counter for the fine tick
   logic [31:0] cyc_q;
   // fine tick counter, 512 per slow tick
   logic [8:0] fine_cnt_q;
   // half-period counter of the blink output
   logic [0:0] blink_cnt_q;

   // fine tick: one pulse every FINE_CYC cycles
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cyc_q <= 32'h0;
         fine_tick <= 1'b0;
      end
      else if (cyc_q == FINE_CYC - 1)
      begin
         cyc_q <= 32'h0;
         fine_tick <= 1'b1;
      end
      else
      begin
         cyc_q <= cyc_q + 32'h1;
         fine_tick <= 1'b0;
      end
   end

   // slow and test-peak ticks share one fine tick counter
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fine_cnt_q <= 9'h000;
         slow_tick <= 1'b0;
         peak_test_tick <= 1'b0;
      end
      else
      begin
         slow_tick <= fine_tick && (fine_cnt_q == 9'(SAFE_TEST_DIV - 1));
         peak_test_tick <= fine_tick && (fine_cnt_q[2:0] == 3'(PEAK_TEST_FINE - 1));
         if (fine_tick)
         begin
            fine_cnt_q <= fine_cnt_q + 9'h001;
         end
      end
   end

   // blink phase: same divider in every mode, so the rate never changes
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         blink_cnt_q <= 1'b0;
         blink_phase <= 1'b0;
      end
      else if (fine_tick)
      begin
         if (blink_cnt_q == 1'(BLINK_HALF_FINE - 1))
         begin
            blink_cnt_q <= 1'b0;
            blink_phase <= ~blink_phase;
         end
         else
         begin
            blink_cnt_q <= blink_cnt_q + 1'b1;
         end
      end
   end

endmodule : cstm_timebase

//--- rtl/cstm_top.sv
// cstm_top: charge state machine, termination timers and status outputs.
// assumes analog comparators outside deliver the sense window flags.
// Functional notes
// - test segments 4, 8, 10 end fast charge
// - trickle charge makes blink output toggle ~4Hz
// - fast charge: switch on, lamp off, blink on
// - fast, trickle and abnormal output encodings
// - lamp pairs with switch; blink stands alone
// - sense outside window: reset, release, blink high
// - test mode: timers /512, peak /64
// - timer select picks safety, peak, initial periods
// - hold mode pauses safety, keeps fast charge
`timescale 1ns/100ps
module cstm_top
   import cstm_pkg::*;
#(
   parameter int unsigned FINE_CYC = FINE_TICK_CYC
)
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic battery_sense_input,
   input wire logic sense_ok,
   input wire logic neg_slope,
   input wire logic at_peak,
   input wire logic [1:0] timer_select,
   input wire logic test_mode,
   input wire logic external_supply_hold_mode,
   output logic charge_switch_output,
   output logic charge_switch_oe_n,
   output logic status_lamp_output,
   output logic status_lamp_oe_n,
   output logic blink_output_n
);

   // raw pins gathered for the synchroniser
   logic [SYNC_N-1:0] pin_raw;
   // first and second synchroniser stages
   logic [SYNC_N-1:0] meta_q;
   logic [SYNC_N-1:0] sync_q;
   // synchronised views
   logic valid_s, ok_s, slope_s, peak_s, test_s, hold_s;
   logic [1:0] tsel_s;
   // timebase ticks
   logic fine_tick, slow_tick, peak_test_tick, blink_phase;
   // state machine
   cstm_state_t state_q, state_d;
   // termination timers in half-minute units
   logic [TMR_W-1:0] safety_q, init_q, peak_q;
   // selected limits
   logic [TMR_W-1:0] safe_lim, peak_lim, init_lim;
   // tick enables per timer, and termination request
   logic safe_tick, peak_tick, init_done, term;

   assign pin_raw = {battery_sense_input, sense_ok, neg_slope, at_peak,
                     timer_select, test_mode, external_supply_hold_mode};

   // two flops per pin; first stage read only by the second
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_N; gi++)
      begin : g_sync
         always_ff @(posedge ref_clk or negedge nrst)
         begin
            if (!nrst)
            begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end
            else
            begin
               meta_q[gi] <= pin_raw[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   assign valid_s = sync_q[7];
   assign ok_s = sync_q[6];
   assign slope_s = sync_q[5];
   assign peak_s = sync_q[4];
   assign tsel_s = sync_q[3:2]; // may be toggled by a tester mid
   assign test_s = sync_q[1];
   assign hold_s = sync_q[0];

   cstm_timebase #(
      .FINE_CYC(FINE_CYC)
   ) u_timebase (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .fine_tick(fine_tick),
      .slow_tick(slow_tick),
      .peak_test_tick(peak_test_tick),
      .blink_phase(blink_phase)
   );

   // period selection from the timer pins; unknown code treated as floating
   always_comb
   begin
      if (tsel_s == TSEL_HIGH)
      begin
         safe_lim = SAFE_HIGH;
         peak_lim = PEAK_HIGH;
         init_lim = INIT_HIGH;
      end
      else if (tsel_s == TSEL_LOW)
      begin
         safe_lim = SAFE_LOW;
         peak_lim = PEAK_LOW;
         init_lim = INIT_LOW;
      end
      else
      begin
         safe_lim = SAFE_FLOAT;
         peak_lim = PEAK_FLOAT;
         init_lim = INIT_FLOAT;
      end
   end

   // test mode runs safety/initial 512x and peak 64x faster
   assign safe_tick = test_s ? fine_tick : slow_tick;
   assign peak_tick = test_s ? peak_test_tick : slow_tick;
   assign init_done = (init_q >= init_lim);

   // any termination path; hold mode masks them all
   assign term = !hold_s && ((safety_q >= safe_lim) ||
                 (init_done && (slope_s || (peak_q >= peak_lim))));

   // next state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         CSTM_ST_RESET:
            state_d = CSTM_ST_CHECK; // restart as after power-on
         CSTM_ST_CHECK:
            state_d = ok_s ? CSTM_ST_FAST : CSTM_ST_ABNORMAL;
         CSTM_ST_FAST:
            if (term)
            begin
               state_d = CSTM_ST_TRICKLE;
            end
         CSTM_ST_ABNORMAL:
            if (ok_s)
            begin
               state_d = CSTM_ST_CHECK;
            end
         default:
            state_d = state_q; // trickle is final until reset
      endcase
      if (!valid_s)
      begin
         state_d = CSTM_ST_RESET; // sense out of window wins
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= CSTM_ST_RESET;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // safety and initial timers; cleared outside fast charge
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         safety_q <= TMR_ZERO;
         init_q <= TMR_ZERO;
      end
      else if (state_q != CSTM_ST_FAST)
      begin
         safety_q <= TMR_ZERO;
         init_q <= TMR_ZERO;
      end
      else if (safe_tick)
      begin
         if (!hold_s && safety_q < safe_lim)
         begin
            safety_q <= safety_q + 9'h001; // paused in hold mode
         end
         if (!init_done)
         begin
            init_q <= init_q + 9'h001;
         end
      end
   end

   // peak timer: runs only while the voltage sits at its peak
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         peak_q <= TMR_ZERO;
      end
      else if (state_q != CSTM_ST_FAST || !peak_s || !init_done)
      begin
         peak_q <= TMR_ZERO;
      end
      else if (peak_tick && peak_q < peak_lim)
      begin
         peak_q <= peak_q + 9'h001;
      end
   end

   // output encodings; open drain is on when driven low
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         charge_switch_output <= 1'b0;
         charge_switch_oe_n <= 1'b1;
         status_lamp_output <= 1'b0;
         status_lamp_oe_n <= 1'b1;
         blink_output_n <= 1'b1;
      end
      else
      begin
         charge_switch_output <= 1'b0;
         status_lamp_output <= 1'b0;
         case (state_q)
            CSTM_ST_FAST:
            begin
               charge_switch_oe_n <= 1'b0; // switch on, lamp off
               status_lamp_oe_n <= 1'b1;
               blink_output_n <= 1'b0;
            end
            CSTM_ST_TRICKLE:
            begin
               charge_switch_oe_n <= 1'b1;
               status_lamp_oe_n <= 1'b0;
               blink_output_n <= blink_phase;
            end
            CSTM_ST_ABNORMAL:
            begin
               charge_switch_oe_n <= 1'b1; // all off
               status_lamp_oe_n <= 1'b1;
               blink_output_n <= 1'b1; // blink held high (off) as well, same as reset and check
            end
            default:
            begin
               charge_switch_oe_n <= 1'b1; // reset and check: released
               status_lamp_oe_n <= 1'b1;
               blink_output_n <= 1'b1;
            end
         endcase
      end
   end

   // checks
   sequence s_fast_term;
      state_q == CSTM_ST_FAST && term && valid_s;
   endsequence
   sequence s_trickle_out;
      state_q == CSTM_ST_TRICKLE ##1 (status_lamp_oe_n == 1'b0 && charge_switch_oe_n);
   endsequence

   AST_TERM_TO_TRICKLE: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_fast_term |=> s_trickle_out)
      else $error("termination did not reach trickle outputs");
   AST_OUT_WINDOW_RESET: assert property (@(posedge ref_clk) disable iff (!nrst)
      !valid_s |=> state_q == CSTM_ST_RESET ##1 (charge_switch_oe_n && status_lamp_oe_n
      && blink_output_n))
      else $error("sense out of window did not release outputs");
   AST_FAST_ENC: assert property (@(posedge ref_clk) disable iff (!nrst)
      state_q == CSTM_ST_FAST |=> !charge_switch_oe_n && status_lamp_oe_n && !blink_output_n)
      else $error("fast charge encoding wrong");
   AST_TRICKLE_BLINK: assert property (@(posedge ref_clk) disable iff (!nrst)
      state_q == CSTM_ST_TRICKLE |=> blink_output_n == $past(blink_phase))
      else $error("trickle blink not following phase");
   AST_ABN_ENC: assert property (@(posedge ref_clk) disable iff (!nrst)
      state_q == CSTM_ST_ABNORMAL |=> charge_switch_oe_n && status_lamp_oe_n && blink_output_n)
      else $error("abnormal encoding wrong");
   AST_HOLD_KEEPS_FAST: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_q == CSTM_ST_FAST && hold_s && valid_s) |=> state_q == CSTM_ST_FAST)
      else $error("hold mode left fast charge");
   AST_HOLD_PAUSE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_q == CSTM_ST_FAST && state_d == CSTM_ST_FAST && hold_s) |=> $stable(safety_q))
      else $error("safety timer ran in hold mode");
   AST_TEST_STEP: assert property (@(posedge ref_clk) disable iff (!nrst)
      (test_s && fine_tick && !hold_s && state_q == CSTM_ST_FAST && state_d == CSTM_ST_FAST
      && safety_q < safe_lim) |=> safety_q == $past(safety_q) + 9'h001)
      else $error("test mode safety step missing");
   AST_RESTART_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
      state_q == CSTM_ST_RESET |=> safety_q == TMR_ZERO && init_q == TMR_ZERO
      && peak_q == TMR_ZERO && state_q != CSTM_ST_TRICKLE)
      else $error("restart did not clear timers");

endmodule : cstm_top

//--- tb/cstm_sense_model.sv
// cstm_sense_model: behavioural battery divider, window comparators and slope detector.
// assumes the bench sets the divided pack voltage in millivolts on sense_mv.
`timescale 1ns/100ps
module cstm_sense_model
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [15:0] sense_mv,
   output logic battery_sense_input,
   output logic sense_ok,
   output logic neg_slope,
   output logic at_peak
);
   int peak_q; // highest voltage since the pack was attached

   // peak tracker, forgotten when the pack is removed
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         peak_q <= 0;
      end
      else if (!battery_sense_input)
      begin
         peak_q <= 0; // pack gone, start over
      end
      else if (int'(sense_mv) > peak_q)
      begin
         peak_q <= int'(sense_mv);
      end
   end

   // comparator flags; the bench keeps the pack in range unless it means not to
   always_comb
   begin
      battery_sense_input = (sense_mv > 16'h01F4) && (sense_mv < 16'h0FA0);
      sense_ok = (sense_mv >= 16'h0320) && (sense_mv <= 16'h0DAC);
      // a drop of 0.25 percent below the peak counts as a slope
      neg_slope = (peak_q != 0) && (int'(sense_mv) * 400 < peak_q * 399);
      at_peak = (peak_q != 0) && (int'(sense_mv) >= peak_q);
   end
endmodule : cstm_sense_model

//--- tb/tb_top.sv
// tb_top: self-checking bench for the charge status and test-mode logic.
// assumes a shortened fine tick so that every test-mode timer ends in a few thousand cycles.
`timescale 1ns/100ps
module tb_top;
   import cstm_pkg::*;
   localparam int unsigned FC = 4; // cycles per fine tick
   localparam logic [3:0] PIN_FAST = 4'h1; // {sw, sw_oe_n, lamp, lamp_oe_n}
   localparam logic [3:0] PIN_TRK = 4'h4;
   localparam logic [3:0] PIN_OFF = 4'h5;
   logic ref_clk, nrst, test_mode, external_supply_hold_mode;
   logic [15:0] sense_mv;
   logic battery_sense_input, sense_ok, neg_slope, at_peak;
   logic [1:0] timer_select;
   logic charge_switch_output, charge_switch_oe_n, status_lamp_output, status_lamp_oe_n;
   logic blink_output_n;
   int failures, n_compared;

   cstm_sense_model u_model (.ref_clk(ref_clk), .nrst(nrst), .sense_mv(sense_mv),
      .battery_sense_input(battery_sense_input), .sense_ok(sense_ok),
      .neg_slope(neg_slope), .at_peak(at_peak));

   cstm_top #(.FINE_CYC(FC)) dut (.ref_clk(ref_clk), .nrst(nrst),
      .battery_sense_input(battery_sense_input), .sense_ok(sense_ok),
      .neg_slope(neg_slope), .at_peak(at_peak), .timer_select(timer_select),
      .test_mode(test_mode), .external_supply_hold_mode(external_supply_hold_mode),
      .charge_switch_output(charge_switch_output), .charge_switch_oe_n(charge_switch_oe_n),
      .status_lamp_output(status_lamp_output), .status_lamp_oe_n(status_lamp_oe_n),
      .blink_output_n(blink_output_n));

   // 125 MHz reference clock
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // one comparison, counted
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   // the single place where the run ends
   task automatic print_verdict();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict

   // the open-drain pins packed as one nibble
   function automatic logic [3:0] pins();
      return {charge_switch_output, charge_switch_oe_n, status_lamp_output, status_lamp_oe_n};
   endfunction : pins

   // inputs move a fixed 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step

   // bounded wait for an output pattern, then judge it
   task automatic wait_pins(input logic [3:0] exp, input int maxc, input string msg);
      int i;
      i = 0;
      while (pins() !== exp && i < maxc)
      begin
         step(1);
         i++;
      end
      check({12'h000, pins()}, {12'h000, exp}, msg);
   endtask : wait_pins

   // reset with the given pack, then see the first charge state
   task automatic restart(input logic [15:0] mv, input logic [1:0] sel, input logic tm,
                          input logic [3:0] exp);
      nrst = 1'b0;
      sense_mv = mv;
      timer_select = sel;
      test_mode = tm;
      external_supply_hold_mode = 1'b0;
      step(2);
      check({12'h000, pins()}, {12'h000, PIN_OFF}, "reset pins");
      check({15'h0000, blink_output_n}, 16'h0001, "reset blink");
      nrst = 1'b1;
      wait_pins(exp, 20, "first state");
      check({15'h0000, blink_output_n}, {15'h0000, exp != PIN_FAST}, "first blink");
   endtask : restart

   // peak timer in test mode, then the blink rate and the window reset
   task automatic t_peak_and_window();
      int n;
      logic b;
      restart(16'h0BB3, TSEL_HIGH, 1'b1, PIN_FAST);
      step(80);
      check({12'h000, pins()}, {12'h000, PIN_FAST}, "peak too early");
      // tight bound: the safety path would only end fast charge far later
      wait_pins(PIN_TRK, 60, "peak trickle");
      b = blink_output_n;
      n = 0;
      while (blink_output_n === b && n < 20)
      begin
         step(1);
         n++;
      end
      b = blink_output_n;
      n = 0;
      while (blink_output_n === b && n < 20)
      begin
         step(1);
         n++;
      end
      check(16'(n), 16'(BLINK_HALF_FINE * FC), "blink half period");
      sense_mv = 16'h1068; // pack removed, divider floats high
      wait_pins(PIN_OFF, 10, "high window reset");
      check({15'h0000, blink_output_n}, 16'h0001, "window blink");
      sense_mv = 16'h012C;
      step(6);
      check({12'h000, pins()}, {12'h000, PIN_OFF}, "low window reset");
      sense_mv = 16'h0BB3;
      wait_pins(PIN_FAST, 20, "restart after window");
      check({15'h0000, blink_output_n}, 16'h0000, "restart blink");
   endtask : t_peak_and_window

   // hold mode pauses safety and masks the slope; releasing it ends fast charge
   task automatic t_hold_slope();
      restart(16'h0BB8, TSEL_HIGH, 1'b1, PIN_FAST);
      external_supply_hold_mode = 1'b1;
      sense_mv = 16'h0BB4; // off the peak, no slope yet
      step(500);
      check({12'h000, pins()}, {12'h000, PIN_FAST}, "hold safety");
      // hold outlasted the safety limit; a running timer would end charge now
      external_supply_hold_mode = 1'b0;
      step(20);
      check({12'h000, pins()}, {12'h000, PIN_FAST}, "safety paused");
      external_supply_hold_mode = 1'b1;
      step(4);
      sense_mv = 16'h0BA4; // clear negative slope
      step(50);
      check({12'h000, pins()}, {12'h000, PIN_FAST}, "hold slope");
      external_supply_hold_mode = 1'b0;
      wait_pins(PIN_TRK, 40, "slope trickle");
   endtask : t_hold_slope

   // safety timer for the high, low and floating timer-select codes, in fine ticks
   task automatic t_safety();
      logic [1:0] sel [3];
      int lim [3];
      sel = '{TSEL_HIGH, TSEL_LOW, TSEL_FLOAT};
      lim = '{80, 160, 320};
      for (int k = 0; k < 3; k++)
      begin
         restart(16'h0BB8, sel[k], 1'b1, PIN_FAST);
         step(2);
         sense_mv = 16'h0BB4; // off the peak so only safety can end it
         step(lim[k] * FC - 80);
         check({12'h000, pins()}, {12'h000, PIN_FAST}, "safety too early");
         wait_pins(PIN_TRK, 160, "safety trickle");
      end
   endtask : t_safety

   // abnormal voltage turns everything off and recovers in normal mode
   task automatic t_abnormal();
      restart(16'h0E74, TSEL_LOW, 1'b0, PIN_OFF);
      step(20);
      check({12'h000, pins()}, {12'h000, PIN_OFF}, "abnormal pins");
      check({15'h0000, blink_output_n}, 16'h0001, "abnormal blink");
      sense_mv = 16'h0BB8;
      wait_pins(PIN_FAST, 20, "abnormal recovery");
      // beyond every test-mode limit of the low select code; normal mode must still be charging
      step(700);
      check({12'h000, pins()}, {12'h000, PIN_FAST}, "normal timers not shortened");
   endtask : t_abnormal

   // watchdog, far beyond the few thousand cycles the tests need
   initial
   begin
      #300000;
      failures++;
      print_verdict();
   end

   // main sequence
   initial
   begin
      failures = 0;
      n_compared = 0;
      nrst = 1'b0;
      sense_mv = 16'h0BB8;
      timer_select = TSEL_HIGH;
      test_mode = 1'b1;
      external_supply_hold_mode = 1'b0;
      step(2);
      nrst = 1'b1;
      t_peak_and_window();
      t_hold_slope();
      t_safety();
      t_abnormal();
      print_verdict();
   end
endmodule : tb_top
